/* verilog/timeout_supervisor.sv */
// Behaviour
// R1: Counter clock is chosen from a 32 kHz, a 1 kHz or an external source.
// R2: Counter is compared with a 16-bit timeout; optional fixed divide by 256.
// R3: Refresh needs keys 0x02A6 then 0x80B4, at most 16 bus clocks apart.
// R4: Window mode accepts a refresh only once the counter has passed the window.
// R5: In window mode an early refresh asserts a reset.
// R6: Unlock with 0x20C5 then 0x28D9, at most 16 bus clocks apart.
// R7: Each configuration register takes one write after reset; later writes are ignored. Here a good unlock reopens all three for one more write each.
// R8: Test mode compares only the upper or lower counter byte with the timeout.
// R9: A bus-clock backup timer forces a reset when the counter clock stops.
// R10: Reaching the timeout asserts reset; a valid refresh clears the counter.
// R11: A wrong key or late second write in either pair asserts a reset.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
module timeout_supervisor #(
  parameter logic [tsup_pkg::BKP_W-1:0] BACKUP_CYCLES = tsup_pkg::BKP_CYCLES_DEF
)
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Counter clock sources, asynchronous to clk_i.
  input  wire logic        osc32k_i,
  input  wire logic        osc1k_i,
  input  wire logic        ext_clk_i,
  // System reset request.
  output logic             rst_req_o
);
  import tsup_pkg::*;

  typedef struct packed {
    logic [2:0]        s32k;
    logic [2:0]        s1k;
    logic [2:0]        sext;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       tmo;
    logic [15:0]       win;
    logic [2:0]        done;
    logic [7:0]        pre;
    logic [15:0]       cnt;
    logic [BKP_W-1:0]  bkp;
    logic              ack;
    logic [31:0]       rdat;
    logic              rst_req;
  } sup_state_t;

  sup_state_t st_ff;
  sup_state_t nxt_st;

  logic req;
  logic wr;
  logic wr_ref;
  logic wr_unl;
  logic ref_ok;
  logic ref_bad;
  logic unl_ok;
  logic unl_bad;
  logic en;
  logic raw;
  logic tick;
  logic hit;
  logic early;
  logic bkp_out;
  logic fire;

  // Counter match, narrowed to one byte in test mode.
  function automatic logic match(input logic [15:0] c, input logic [15:0] t, input logic test, input logic hi);
    if (!test)
      match = (c == t);
    else if (hi)
      match = (c[15:8] == t[15:8]);
    else
      match = (c[7:0] == t[7:0]);
  endfunction : match

  // A single-cycle Wishbone answer; key and config writes need both low lanes.
  assign req    = cyc_i && stb_i && !st_ff.ack;
  assign wr     = req && we_i && sel_i[1:0] == 2'h3;
  assign wr_ref = wr && adr_i == ADDR_REFRESH;
  assign wr_unl = wr && adr_i == ADDR_UNLOCK;
  assign ack_o  = st_ff.ack;
  assign dat_o  = st_ff.rdat;
  assign rst_req_o = st_ff.rst_req;

  key_sequencer #(
    .KEY_FIRST  (KEY_REF1),
    .KEY_SECOND (KEY_REF2)
  ) u_refresh (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .wr_i  (wr_ref),
    .key_i (dat_i[15:0]),
    .ok_o  (ref_ok),
    .bad_o (ref_bad)
  );

  key_sequencer #(
    .KEY_FIRST  (KEY_UNL1),
    .KEY_SECOND (KEY_UNL2)
  ) u_unlock (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .wr_i  (wr_unl),
    .key_i (dat_i[15:0]),
    .ok_o  (unl_ok),
    .bad_o (unl_bad)
  );

  // Edge of the chosen source; edges are read from the second and third stages only.
  always_comb
  begin
    case (st_ff.ctrl[CTRL_CLK+:2])
      SRC_1K:  raw = st_ff.s1k[1] && !st_ff.s1k[2]; // R1
      SRC_EXT: raw = st_ff.sext[1] && !st_ff.sext[2]; // R1
      default: raw = st_ff.s32k[1] && !st_ff.s32k[2]; // R1
    endcase
  end

  // The divider only lets every 256th source edge through.
  assign en      = st_ff.ctrl[CTRL_EN];
  assign tick    = st_ff.ctrl[CTRL_PRE] ? (raw && st_ff.pre == PRE_LAST) : raw; // R2
  assign hit     = en && match(st_ff.cnt, st_ff.tmo, st_ff.ctrl[CTRL_TEST], st_ff.ctrl[CTRL_TBYTE]); // R2 R8
  assign early   = st_ff.ctrl[CTRL_WIN] && st_ff.cnt < st_ff.win; // R4
  assign bkp_out = en && st_ff.bkp == BACKUP_CYCLES - 24'h000001; // R9
  assign fire    = hit || (en && ref_ok && early) || ref_bad || unl_bad || bkp_out; // R5 R10 R11

  // Next state of the whole block.
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.s32k    = {st_ff.s32k[1:0], osc32k_i};
    nxt_st.s1k     = {st_ff.s1k[1:0], osc1k_i};
    nxt_st.sext    = {st_ff.sext[1:0], ext_clk_i};
    nxt_st.ack     = req;
    nxt_st.rst_req = fire;
    nxt_st.rdat    = 32'h00000000;
    if (req && !we_i)
    begin
      case (adr_i)
        ADDR_CTRL:    nxt_st.rdat = {25'h0, st_ff.ctrl};
        ADDR_TIMEOUT: nxt_st.rdat = {16'h0000, st_ff.tmo};
        ADDR_WINDOW:  nxt_st.rdat = {16'h0000, st_ff.win};
        ADDR_COUNT:   nxt_st.rdat = {16'h0000, st_ff.cnt};
        ADDR_STATUS:  nxt_st.rdat = {28'h0000000, en, st_ff.done};
        default:      nxt_st.rdat = 32'h00000000;
      endcase
    end
    // Each register locks after its first write; a good unlock opens all three again.
    if (wr && adr_i == ADDR_CTRL && !st_ff.done[DONE_CTRL])
    begin
      nxt_st.ctrl            = dat_i[CTRL_W-1:0]; // R7
      nxt_st.done[DONE_CTRL] = 1'b1;
    end
    if (wr && adr_i == ADDR_TIMEOUT && !st_ff.done[DONE_TMO])
    begin
      nxt_st.tmo            = dat_i[15:0]; // R7
      nxt_st.done[DONE_TMO] = 1'b1;
    end
    if (wr && adr_i == ADDR_WINDOW && !st_ff.done[DONE_WIN])
    begin
      nxt_st.win            = dat_i[15:0]; // R7
      nxt_st.done[DONE_WIN] = 1'b1;
    end
    if (unl_ok)
      nxt_st.done = 3'h0; // R6
    // Prescaler holds at zero unless enabled with the divider on, so a mode switch starts from a known phase.
    if (!en || !st_ff.ctrl[CTRL_PRE])
      nxt_st.pre = 8'h00;
    else if (raw)
      nxt_st.pre = st_ff.pre + 8'h01; // R2
    // Counter clears on disable, on any reset request and on an accepted refresh.
    if (!en || fire || ref_ok)
      nxt_st.cnt = 16'h0000; // R10
    else if (tick)
      nxt_st.cnt = st_ff.cnt + 16'h0001; // R2
    // Backup timer runs on clk_i and restarts on every source edge.
    if (!en || raw || bkp_out)
      nxt_st.bkp = '0;
    else
      nxt_st.bkp = st_ff.bkp + 24'h000001; // R9
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff      <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.tmo  <= TIMEOUT_RST;
      st_ff.win  <= WINDOW_RST;
    end
    else
      st_ff <= nxt_st;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Bus answer held longer than one cycle.");

  property p_tick_count;
    en && tick && !fire && !ref_ok |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001;
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("Counter missed a tick."); // R2

  property p_prescale;
    en && st_ff.ctrl[CTRL_PRE] && st_ff.pre != PRE_LAST |-> !tick;
  endproperty
  a_prescale: assert property (p_prescale) else $error("Prescaler passed an early edge."); // R2

  property p_timeout;
    hit |=> rst_req_o && st_ff.cnt == 16'h0000;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout did not request reset."); // R10

  property p_early;
    en && st_ff.ctrl[CTRL_WIN] && ref_ok && st_ff.cnt < st_ff.win |=> rst_req_o;
  endproperty
  a_early: assert property (p_early) else $error("Early refresh not punished."); // R5

  property p_refresh;
    en && ref_ok && !early |=> st_ff.cnt == 16'h0000;
  endproperty
  a_refresh: assert property (p_refresh) else $error("Accepted refresh did not clear counter."); // R4

  property p_write_once;
    st_ff.done[DONE_CTRL] && st_ff.done[DONE_TMO] |=> $stable(st_ff.ctrl) && $stable(st_ff.tmo);
  endproperty
  a_write_once: assert property (p_write_once) else $error("Locked configuration changed."); // R7

  property p_test_low;
    en && st_ff.ctrl[CTRL_TEST] && !st_ff.ctrl[CTRL_TBYTE] && st_ff.cnt[7:0] == st_ff.tmo[7:0] |=> rst_req_o;
  endproperty
  a_test_low: assert property (p_test_low) else $error("Low byte test match missed."); // R8

  property p_backup;
    en && !raw && st_ff.bkp == BACKUP_CYCLES - 24'h000001 |=> rst_req_o && st_ff.bkp == '0;
  endproperty
  a_backup: assert property (p_backup) else $error("Backup timer did not reset."); // R9

  property p_bad_key;
    ref_bad || unl_bad |=> rst_req_o;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("Bad key sequence not punished."); // R11

endmodule : timeout_supervisor

/* verilog/tsup_pkg.sv */
package tsup_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_WINDOW  = 8'h08;
  localparam logic [7:0] ADDR_REFRESH = 8'h0C;
  localparam logic [7:0] ADDR_UNLOCK  = 8'h10;
  localparam logic [7:0] ADDR_COUNT   = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // Control field positions.
  localparam int CTRL_W     = 7;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_WIN   = 1;
  localparam int CTRL_PRE   = 2;
  localparam int CTRL_CLK   = 3;
  localparam int CTRL_TEST  = 5;
  localparam int CTRL_TBYTE = 6;

  // Write-once tracking bits, one per configuration register.
  localparam int DONE_CTRL = 0;
  localparam int DONE_TMO  = 1;
  localparam int DONE_WIN  = 2;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST    = 7'h00;
  localparam logic [15:0]       TIMEOUT_RST = 16'hFFFF;
  localparam logic [15:0]       WINDOW_RST  = 16'h0000;

  // Counter clock source codes.
  localparam logic [1:0] SRC_32K = 2'h0;
  localparam logic [1:0] SRC_1K  = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // Key values and the longest gap between the two writes of a pair.
  localparam logic [15:0] KEY_REF1 = 16'h02A6;
  localparam logic [15:0] KEY_REF2 = 16'h80B4;
  localparam logic [15:0] KEY_UNL1 = 16'h20C5;
  localparam logic [15:0] KEY_UNL2 = 16'h28D9;
  localparam int          GAP_W    = 5;
  localparam logic [GAP_W-1:0] KEY_GAP = 5'h10;
  localparam logic [GAP_W-1:0] GAP_ONE = 5'h01;

  // Fixed prescaler of 256 counter clock edges.
  localparam logic [7:0] PRE_LAST = 8'hFF;

  // Backup timer: a silent counter clock for this long forces a reset.
  localparam int BACKUP_US = 4000;
  localparam int CLK_MHZ   = 10;
  localparam int BKP_W     = 24;
  localparam logic [BKP_W-1:0] BKP_CYCLES_DEF = 24'(BACKUP_US * CLK_MHZ);

  typedef enum logic {SEQ_IDLE, SEQ_ARMED} seq_state_t;

endpackage : tsup_pkg

/* verilog/key_sequencer.sv */
module key_sequencer #(
  parameter logic [15:0] KEY_FIRST  = 16'h0000,
  parameter logic [15:0] KEY_SECOND = 16'h0000
)
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Key write strobe and value.
  input  wire logic        wr_i,
  input  wire logic [15:0] key_i,
  // Result pulses.
  output logic             ok_o,
  output logic             bad_o
);
  import tsup_pkg::*;

  typedef struct packed {
    seq_state_t       st;
    logic [GAP_W-1:0] gap;
  } seq_t;

  seq_t seq_ff;
  seq_t nxt_seq;

  // A wrong key, a late second key or a lone first key all end the pair as bad.
  always_comb
  begin
    nxt_seq = seq_ff;
    ok_o    = 1'b0;
    bad_o   = 1'b0;
    case (seq_ff.st)
      SEQ_IDLE:
      begin
        if (wr_i && key_i == KEY_FIRST)
        begin
          nxt_seq.st  = SEQ_ARMED;
          nxt_seq.gap = GAP_ONE;
        end
        else if (wr_i)
          bad_o = 1'b1;
      end
      SEQ_ARMED:
      begin
        if (wr_i)
        begin
          nxt_seq.st = SEQ_IDLE;
          ok_o       = (key_i == KEY_SECOND);
          bad_o      = (key_i != KEY_SECOND);
        end
        else if (seq_ff.gap == KEY_GAP)
        begin
          nxt_seq.st = SEQ_IDLE;
          bad_o      = 1'b1; // R3 R6
        end
        else
          nxt_seq.gap = seq_ff.gap + GAP_ONE;
      end
      default: nxt_seq.st = SEQ_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seq_ff <= '{st: SEQ_IDLE, gap: '0};
    else
      seq_ff <= nxt_seq;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_late_bad;
    seq_ff.st == SEQ_ARMED && seq_ff.gap == KEY_GAP && !wr_i |-> bad_o ##1 seq_ff.st == SEQ_IDLE;
  endproperty
  a_late_bad: assert property (p_late_bad) else $error("Late second key not refused."); // R3

  property p_pair_ok;
    ok_o |-> seq_ff.st == SEQ_ARMED && seq_ff.gap <= KEY_GAP && key_i == KEY_SECOND;
  endproperty
  a_pair_ok: assert property (p_pair_ok) else $error("Key pair accepted without a valid first key."); // R6

endmodule : key_sequencer

/* test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsup_pkg::*;

  // Small backup limit so a stalled counter clock is caught quickly.
  localparam int BKP = 200;

  // Design ports and bench state.
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        rst_req_o;
  logic [2:0]  src;
  logic        run;
  logic [3:0]  div;
  logic [31:0] rng;
  logic [31:0] q;
  logic [15:0] k;
  int          miscompares;
  int          checks_done;
  int          pulses;
  int          cycles;
  int          p0;
  int          per [3] = '{8, 16, 4};

  timeout_supervisor #(.BACKUP_CYCLES(24'(BKP))) timeout_supervisor_inst
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cyc_i     (cyc_i),
    .stb_i     (stb_i),
    .we_i      (we_i),
    .adr_i     (adr_i),
    .sel_i     (sel_i),
    .dat_i     (dat_i),
    .dat_o     (dat_o),
    .ack_o     (ack_o),
    .osc32k_i  (src[0]),
    .osc1k_i   (src[1]),
    .ext_clk_i (src[2]),
    .rst_req_o (rst_req_o)
  );

  // Bus clock of 100 ns.
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Counter clocks at periods of 8, 16 and 4 bus clocks; they hold still when run is low.
  // Reset pulses are counted here, and the cycle ceiling cuts a hang short.
  always @(posedge clk_i)
  begin
    div <= div + 4'h1;
    if (run)
      src <= src ^ {div[0], &div[2:0], &div[1:0]};
    if (rst_req_o === 1'b1)
      pulses <= pulses + 1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    checks_done++;
    if ($isunknown(g) || !(g >= lo && g <= hi))
    begin
      miscompares++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd

  task automatic pair(input logic [7:0] a, input logic [15:0] k1, input logic [15:0] k2, input int gap);
    wb(1'b1, a, {16'h0, k1});
    repeat (gap) @(posedge clk_i);
    wb(1'b1, a, {16'h0, k2});
  endtask : pair

  task automatic pulses_in(input int n, input int lo, input int hi);
    repeat (n) @(posedge clk_i);
    chk_rng("reset pulses", lo, hi, 32'(pulses - p0));
    p0 = pulses;
  endtask : pulses_in

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    run   <= 1'b1;
    p0 = pulses;
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Main sequence; every scenario starts from reset so write-once state is fresh.
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, src, run, div} = '0;
    sel_i = 4'hF;
    rng = 32'h6521;
    {miscompares, checks_done, pulses, cycles, p0} = '0;
    do_reset();
    rd("ctrl", ADDR_CTRL, 32'h0);
    rd("timeout", ADDR_TIMEOUT, 32'h0000FFFF);
    rd("window", ADDR_WINDOW, 32'h0);
    rd("unmapped", 8'h1C, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      do_reset();
      wb(1'b1, ADDR_CTRL, 32'(s * 8 + 1));
      repeat (160) @(posedge clk_i);
      wb(1'b0, ADDR_COUNT, 32'h0);
      chk_rng("count", 160 / per[s] - 3, 160 / per[s] + 3, q);
      pair(ADDR_REFRESH, KEY_REF1, KEY_REF2, 0);
      wb(1'b0, ADDR_COUNT, 32'h0);
      chk_rng("count after refresh", 0, 2, q);
      pulses_in(2, 0, 0);
    end
    do_reset();
    wb(1'b1, ADDR_CTRL, 32'h15);
    repeat (1100) @(posedge clk_i);
    rd("prescaled count", ADDR_COUNT, 32'h1);
    do_reset();
    wb(1'b1, ADDR_TIMEOUT, 32'h3);
    wb(1'b1, ADDR_CTRL, 32'h11);
    pulses_in(40, 3, 3);
    for (int b = 0; b < 2; b++)
    begin
      do_reset();
      wb(1'b1, ADDR_TIMEOUT, b ? 32'h00C8 : 32'h7F05);
      wb(1'b1, ADDR_CTRL, 32'(b * 64 + 32'h31));
      pulses_in(40, b ? 36 : 1, b ? 40 : 2);
    end
    do_reset();
    k = 16'(xs());
    k = (k == KEY_REF2) ? ~k : k;
    pair(ADDR_REFRESH, KEY_REF1, k, 0);
    pulses_in(4, 1, 1);
    k = 16'(xs());
    k = (k == KEY_UNL1) ? ~k : k;
    wb(1'b1, ADDR_UNLOCK, {16'h0, k});
    pulses_in(4, 1, 1);
    pair(ADDR_REFRESH, KEY_REF1, KEY_REF2, 20);
    pulses_in(4, 2, 2);
    pair(ADDR_UNLOCK, KEY_UNL1, KEY_UNL2, 20);
    pulses_in(4, 2, 2);
    // Taken edges 16 apart still pair; 17 apart is late, and the stray second key is bad too.
    pair(ADDR_REFRESH, KEY_REF1, KEY_REF2, 13);
    pulses_in(4, 0, 0);
    pair(ADDR_UNLOCK, KEY_UNL1, KEY_UNL2, 14);
    pulses_in(4, 2, 2);
    do_reset();
    wb(1'b1, ADDR_WINDOW, 32'h00000014);
    wb(1'b1, ADDR_CTRL, 32'h13);
    pair(ADDR_REFRESH, KEY_REF1, KEY_REF2, 0);
    pulses_in(4, 1, 1);
    repeat (120) @(posedge clk_i);
    pair(ADDR_REFRESH, KEY_REF1, KEY_REF2, 0);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk_rng("count after window refresh", 0, 2, q);
    pulses_in(2, 0, 0);
    do_reset();
    k = 16'(xs());
    wb(1'b1, ADDR_TIMEOUT, {16'h0, k});
    wb(1'b1, ADDR_TIMEOUT, {16'h0, ~k});
    rd("timeout once", ADDR_TIMEOUT, {16'h0, k});
    rd("status", ADDR_STATUS, 32'h00000002);
    pair(ADDR_UNLOCK, KEY_UNL1, KEY_UNL2, 0);
    wb(1'b1, ADDR_TIMEOUT, {16'h0, ~k});
    rd("timeout unlocked", ADDR_TIMEOUT, {16'h0, ~k});
    do_reset();
    wb(1'b1, ADDR_CTRL, 32'h11);
    repeat (20) @(posedge clk_i);
    run <= 1'b0;
    pulses_in(BKP + 60, 1, 1);
    give_verdict();
  end

endmodule : tb_top
